//--- src/tmc_mode_ctrl.v
// Mode and pin-function control of a full-speed OTG transceiver, AHB-Lite register slave
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tmc_defs.vh"
module tmc_mode_ctrl #(
	parameter [15:0] VENDOR_CODE = 16'h1234,
	parameter [15:0] PRODUCT_CODE = 16'h5678
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	input wire suspend_pin,
	input wire speed_pin,
	input wire driver_output_enable_n,
	input wire data_or_plus_pin_i,
	output reg data_or_plus_pin_o,
	output reg data_or_plus_pin_oen,
	input wire single_zero_or_minus_pin_i,
	output reg single_zero_or_minus_pin_o,
	output reg single_zero_or_minus_pin_oen,
	input wire rx_diff,
	input wire rx_plus,
	input wire rx_minus,
	input wire rx_se0,
	input wire [7:0] line_status,
	output reg diff_receive_out,
	output reg diff_receive_oen,
	output reg plus_single_ended_out,
	output reg minus_single_ended_out,
	output reg line_plus_o,
	output reg line_plus_oen,
	output reg line_minus_o,
	output reg line_minus_oen,
	output reg full_speed,
	output reg diff_driver_mode,
	output reg [1:0] op_mode,
	output reg power_down,
	output reg analog_keep_on,
	output reg [3:0] line_pull,
	output reg id_ground,
	output reg vbus_supply,
	output reg vbus_discharge,
	output reg vbus_charge,
	output reg ext_pump_en,
	output reg rec_bias
);

// ****************************************
// Input synchronisation
// ****************************************
wire [16:0] sync_q;
wire susp_s;
wire speed_s;
wire oe_n_s;
wire dpin_s;
wire spin_s;
wire rx_diff_s;
wire rx_plus_s;
wire rx_minus_s;
wire rx_se0_s;
wire [7:0] src_s;

tmc_sync #(
	.WIDTH(17)
) u_sync (
	.hclk(hclk),
	.hresetn(hresetn),
	.async_in({line_status, rx_se0, rx_minus, rx_plus, rx_diff, single_zero_or_minus_pin_i,
		data_or_plus_pin_i, driver_output_enable_n, speed_pin, suspend_pin}),
	.sync_out(sync_q)
);

assign susp_s = sync_q[0];
assign speed_s = sync_q[1];
assign oe_n_s = sync_q[2];
assign dpin_s = sync_q[3];
assign spin_s = sync_q[4];
assign rx_diff_s = sync_q[5];
assign rx_plus_s = sync_q[6];
assign rx_minus_s = sync_q[7];
assign rx_se0_s = sync_q[8];
assign src_s = sync_q[16:9];

// ****************************************
// Registers
// ****************************************
reg [7:0] ctrl1_r;
reg [7:0] ctrl2_r;
reg [7:0] ctrl3_r;
reg [7:0] latch_r;
reg [7:0] mfall_r;
reg [7:0] mrise_r;
reg [7:0] src_prev_r;
reg [7:0] ctrl1_nxt;
reg [7:0] ctrl2_nxt;
reg [7:0] ctrl3_nxt;
reg [7:0] latch_nxt;
reg [7:0] mfall_nxt;
reg [7:0] mrise_nxt;
reg wr_pend_r;
reg [5:0] wr_idx_r;
reg rd_pend_r;
reg [5:0] rd_idx_r;
reg [7:0] wd;
reg [7:0] irq_evt;
reg [31:0] rd_val;
wire addr_ok;

assign addr_ok = hsel & htrans[1] & hready;

// ****************************************
// AHB-Lite slave control
// ****************************************
// Reads take one wait state so a write in the cycle before is already visible
// External master access
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		wr_pend_r <= 1'b0;
		wr_idx_r <= 6'h00;
		rd_pend_r <= 1'b0;
		rd_idx_r <= 6'h00;
		hreadyout <= 1'b1;
		hrdata <= 32'h00000000;
		hresp <= 1'b0;
	end
	else
	begin
		wr_pend_r <= addr_ok & hwrite;
		if (addr_ok)
		begin
			wr_idx_r <= haddr[7:2];
			rd_idx_r <= haddr[7:2];
		end
		rd_pend_r <= addr_ok & ~hwrite;
		if (addr_ok & ~hwrite)
			hreadyout <= 1'b0;
		else
			hreadyout <= 1'b1;
		if (rd_pend_r)
			hrdata <= rd_val;
	end
end

// Reads from set or clear address alike
always @*
begin
	case (rd_idx_r)
		`TMC_IDX_VENDOR: rd_val = {16'h0000, VENDOR_CODE};
		`TMC_IDX_PRODUCT: rd_val = {16'h0000, PRODUCT_CODE};
		`TMC_IDX_C1_SET, `TMC_IDX_C1_CLR: rd_val = {24'h000000, ctrl1_r};
		`TMC_IDX_C2_SET, `TMC_IDX_C2_CLR: rd_val = {24'h000000, ctrl2_r};
		`TMC_IDX_C3_SET, `TMC_IDX_C3_CLR: rd_val = {24'h000000, ctrl3_r};
		`TMC_IDX_SOURCE: rd_val = {24'h000000, src_s};
		`TMC_IDX_LATCH_SET, `TMC_IDX_LATCH_CLR: rd_val = {24'h000000, latch_r};
		`TMC_IDX_MFALL_SET, `TMC_IDX_MFALL_CLR: rd_val = {24'h000000, mfall_r};
		`TMC_IDX_MRISE_SET, `TMC_IDX_MRISE_CLR: rd_val = {24'h000000, mrise_r};
		default: rd_val = 32'h00000000;
	endcase
end

// ****************************************
// Register update
// ****************************************
always @*
begin
	wd = hwdata[7:0];
	ctrl1_nxt = ctrl1_r;
	ctrl2_nxt = ctrl2_r;
	ctrl3_nxt = ctrl3_r;
	latch_nxt = latch_r;
	mfall_nxt = mfall_r;
	mrise_nxt = mrise_r;
	if (wr_pend_r)
	begin
		case (wr_idx_r)
			`TMC_IDX_C1_SET: ctrl1_nxt = ctrl1_r | (wd & `TMC_C1_WMASK);
			`TMC_IDX_C1_CLR: ctrl1_nxt = ctrl1_r & ~wd;
			`TMC_IDX_C2_SET: ctrl2_nxt = ctrl2_r | wd;
			`TMC_IDX_C2_CLR: ctrl2_nxt = ctrl2_r & ~wd;
			`TMC_IDX_C3_SET: ctrl3_nxt = ctrl3_r | (wd & `TMC_C3_WMASK);
			`TMC_IDX_C3_CLR: ctrl3_nxt = ctrl3_r & ~wd;
			`TMC_IDX_LATCH_SET: latch_nxt = latch_r | wd;
			`TMC_IDX_LATCH_CLR: latch_nxt = latch_r & ~wd;
			`TMC_IDX_MFALL_SET: mfall_nxt = mfall_r | wd;
			`TMC_IDX_MFALL_CLR: mfall_nxt = mfall_r & ~wd;
			`TMC_IDX_MRISE_SET: mrise_nxt = mrise_r | wd;
			`TMC_IDX_MRISE_CLR: mrise_nxt = mrise_r & ~wd;
			default: ctrl1_nxt = ctrl1_r;
		endcase
	end
	if (ctrl1_nxt[`TMC_C1_TRANSP] & ctrl1_nxt[`TMC_C1_UART])
		ctrl1_nxt[`TMC_C1_TRANSP] = 1'b0;
	// Bus power controls are exclusive; drive beats discharge beats charge
	if (ctrl2_nxt[`TMC_C2_VBUS_DRV])
	begin
		ctrl2_nxt[`TMC_C2_VBUS_DIS] = 1'b0;
		ctrl2_nxt[`TMC_C2_VBUS_CHG] = 1'b0;
	end
	else if (ctrl2_nxt[`TMC_C2_VBUS_DIS])
		ctrl2_nxt[`TMC_C2_VBUS_CHG] = 1'b0;
	// Edge events per mask; the reconnect event sleeps in power-down
	irq_evt = (src_s & ~src_prev_r & mrise_r) | (~src_s & src_prev_r & mfall_r);
	if (power_down)
		irq_evt[`TMC_IRQ_BDIS_ACON] = 1'b0;
	latch_nxt = latch_nxt | irq_evt;
end

always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		ctrl1_r <= `TMC_C1_RESET;
		ctrl2_r <= `TMC_C2_RESET;
		ctrl3_r <= `TMC_C3_RESET;
		latch_r <= 8'h00;
		mfall_r <= 8'h00;
		mrise_r <= 8'h00;
		src_prev_r <= 8'h00;
	end
	else
	begin
		ctrl1_r <= ctrl1_nxt;
		ctrl2_r <= ctrl2_nxt;
		ctrl3_r <= ctrl3_nxt;
		latch_r <= latch_nxt;
		mfall_r <= mfall_nxt;
		mrise_r <= mrise_nxt;
		src_prev_r <= src_s;
	end
end

// ****************************************
// Mode decode
// ****************************************
wire pd_w;
wire enc_w;
wire bidi_w;
wire audio_w;
wire uart_w;
wire usb_w;
wire pins_out_w;

assign pd_w = ctrl1_r[`TMC_C1_SUSPEND] & susp_s;
assign enc_w = ctrl1_r[`TMC_C1_ENC];
assign bidi_w = ctrl3_r[`TMC_C3_BIDI];
assign audio_w = ~ctrl1_r[`TMC_C1_TRANSP] & ~ctrl1_r[`TMC_C1_UART] & oe_n_s & (ctrl2_r == 8'h00);
// Mode from test and UART bits
assign uart_w = ctrl1_r[`TMC_C1_UART];
assign usb_w = ~ctrl1_r[`TMC_C1_TRANSP] & ~uart_w & ~audio_w;
assign pins_out_w = usb_w & bidi_w & oe_n_s;

// ****************************************
// Outputs
// ****************************************
// Every pin output is registered, adding one cycle to the synchroniser delay
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		op_mode <= `TMC_MODE_USB;
		power_down <= 1'b0;
		analog_keep_on <= 1'b1;
		full_speed <= 1'b0;
		diff_driver_mode <= 1'b1;
		diff_receive_out <= 1'b0;
		diff_receive_oen <= 1'b1;
		plus_single_ended_out <= 1'b0;
		minus_single_ended_out <= 1'b0;
		data_or_plus_pin_o <= 1'b0;
		data_or_plus_pin_oen <= 1'b1;
		single_zero_or_minus_pin_o <= 1'b0;
		single_zero_or_minus_pin_oen <= 1'b1;
		line_plus_o <= 1'b0;
		line_plus_oen <= 1'b1;
		line_minus_o <= 1'b0;
		line_minus_oen <= 1'b1;
		line_pull <= 4'h0;
		id_ground <= 1'b0;
		vbus_supply <= 1'b0;
		vbus_discharge <= 1'b0;
		vbus_charge <= 1'b0;
		ext_pump_en <= 1'b0;
		rec_bias <= 1'b0;
	end
	else
	begin
		if (audio_w)
			op_mode <= `TMC_MODE_AUDIO;
		else if (uart_w)
			op_mode <= `TMC_MODE_UART;
		else if (ctrl1_r[`TMC_C1_TRANSP])
			op_mode <= `TMC_MODE_FORBID;
		else
			op_mode <= `TMC_MODE_USB;
		power_down <= pd_w;
		analog_keep_on <= ~pd_w | ctrl2_r[`TMC_C2_VBUS_DRV] | ctrl2_r[`TMC_C2_VBUS_DIS]
			| ctrl2_r[`TMC_C2_VBUS_CHG] | ctrl2_r[0] | ctrl2_r[1]
			| ctrl3_r[`TMC_C3_REC_BIAS] | ctrl3_r[`TMC_C3_PSW] | ctrl3_r[`TMC_C3_AUDIO_EN];
		full_speed <= ctrl1_r[`TMC_C1_SPEED] & speed_s;
		diff_driver_mode <= ~uart_w;
		plus_single_ended_out <= rx_plus_s;
		minus_single_ended_out <= rx_minus_s;
		diff_receive_out <= rx_diff_s & ~enc_w;
		diff_receive_oen <= ~(~enc_w & oe_n_s);
		// Shared digital pins
		if (uart_w)
		begin
			// Direction 1 passes line to pin
			data_or_plus_pin_o <= rx_plus_s;
			data_or_plus_pin_oen <= ~ctrl3_r[`TMC_C3_BDIR1];
			single_zero_or_minus_pin_o <= rx_minus_s;
			single_zero_or_minus_pin_oen <= ~ctrl3_r[`TMC_C3_BDIR0];
		end
		else if (enc_w)
		begin
			data_or_plus_pin_o <= rx_diff_s;
			data_or_plus_pin_oen <= ~pins_out_w;
			single_zero_or_minus_pin_o <= rx_se0_s;
			single_zero_or_minus_pin_oen <= ~pins_out_w;
		end
		else
		begin
			data_or_plus_pin_o <= rx_plus_s;
			data_or_plus_pin_oen <= ~pins_out_w;
			single_zero_or_minus_pin_o <= rx_minus_s;
			single_zero_or_minus_pin_oen <= ~pins_out_w;
		end
		// Line drivers
		if (uart_w & ~pd_w)
		begin
			// Direction 0 drives line from pin
			line_plus_o <= dpin_s;
			line_plus_oen <= ctrl3_r[`TMC_C3_BDIR1];
			line_minus_o <= spin_s;
			line_minus_oen <= ctrl3_r[`TMC_C3_BDIR0];
		end
		else if (usb_w & ~pd_w & ~oe_n_s)
		begin
			line_plus_o <= enc_w ? (dpin_s & ~spin_s) : dpin_s;
			line_minus_o <= enc_w ? (~dpin_s & ~spin_s) : spin_s;
			line_plus_oen <= 1'b0;
			line_minus_oen <= 1'b0;
		end
		else
		begin
			line_plus_o <= 1'b0;
			line_plus_oen <= 1'b1;
			line_minus_o <= 1'b0;
			line_minus_oen <= 1'b1;
		end
		// Pulls and ID released in audio
		line_pull <= audio_w ? 4'h0 : ctrl2_r[3:0];
		id_ground <= ctrl2_r[`TMC_C2_ID_GND] & ~audio_w;
		vbus_supply <= ctrl2_r[`TMC_C2_VBUS_DRV] & ~audio_w;
		vbus_discharge <= ctrl2_r[`TMC_C2_VBUS_DIS];
		vbus_charge <= ctrl2_r[`TMC_C2_VBUS_CHG] & ~audio_w;
		ext_pump_en <= ctrl3_r[`TMC_C3_PSW] & ~audio_w;
		rec_bias <= ctrl3_r[`TMC_C3_REC_BIAS];
	end
end

endmodule

//--- src/tmc_defs.vh
// Constants for the transceiver mode control block
`ifndef TMC_DEFS_VH
`define TMC_DEFS_VH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define TMC_IDX_VENDOR 6'h00
`define TMC_IDX_PRODUCT 6'h02
`define TMC_IDX_C1_SET 6'h04
`define TMC_IDX_C1_CLR 6'h05
`define TMC_IDX_C2_SET 6'h06
`define TMC_IDX_C2_CLR 6'h07
`define TMC_IDX_SOURCE 6'h08
`define TMC_IDX_LATCH_SET 6'h0a
`define TMC_IDX_LATCH_CLR 6'h0b
`define TMC_IDX_MFALL_SET 6'h0c
`define TMC_IDX_MFALL_CLR 6'h0d
`define TMC_IDX_MRISE_SET 6'h0e
`define TMC_IDX_MRISE_CLR 6'h0f
`define TMC_IDX_C3_SET 6'h12
`define TMC_IDX_C3_CLR 6'h13

// ****************************************
// Reset values and writable masks
// ****************************************
`define TMC_C1_RESET 8'h03
`define TMC_C2_RESET 8'h0c
`define TMC_C3_RESET 8'h14
`define TMC_C1_WMASK 8'h7f
`define TMC_C3_WMASK 8'h7e

// ****************************************
// Field positions
// ****************************************
`define TMC_C1_SPEED 0
`define TMC_C1_SUSPEND 1
`define TMC_C1_ENC 2
`define TMC_C1_TRANSP 3
`define TMC_C1_UART 6
`define TMC_C2_ID_GND 4
`define TMC_C2_VBUS_DRV 5
`define TMC_C2_VBUS_DIS 6
`define TMC_C2_VBUS_CHG 7
`define TMC_C3_REC_BIAS 1
`define TMC_C3_BIDI 2
`define TMC_C3_BDIR0 3
`define TMC_C3_BDIR1 4
`define TMC_C3_AUDIO_EN 5
`define TMC_C3_PSW 6
`define TMC_IRQ_BDIS_ACON 6

// ****************************************
// Operating mode codes
// ****************************************
`define TMC_MODE_USB 2'h0
`define TMC_MODE_UART 2'h1
`define TMC_MODE_AUDIO 2'h2
`define TMC_MODE_FORBID 2'h3

`endif

//--- src/tmc_sync.v
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module tmc_sync #(
	parameter WIDTH = 1
) (
	input wire hclk,
	input wire hresetn,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

// First stage is read by the second stage only
reg [WIDTH-1:0] meta_r;

always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		meta_r <= {WIDTH{1'b0}};
		sync_out <= {WIDTH{1'b0}};
	end
	else
	begin
		meta_r <= async_in;
		sync_out <= meta_r;
	end
end

endmodule

//--- test/tmc_mode_ctrl_asserts.sv
// Port-level assertions for the transceiver mode control block
`timescale 1ns/1ps
`include "tmc_defs.vh"
module tmc_mode_ctrl_asserts (
	input wire hclk,
	input wire hresetn,
	input wire suspend_pin,
	input wire speed_pin,
	input wire driver_output_enable_n,
	input wire rx_plus,
	input wire data_or_plus_pin_oen,
	input wire diff_receive_oen,
	input wire [3:0] line_pull,
	input wire line_plus_oen,
	input wire line_minus_oen,
	input wire id_ground,
	input wire vbus_supply,
	input wire [1:0] op_mode,
	input wire diff_driver_mode,
	input wire power_down,
	input wire analog_keep_on,
	input wire full_speed,
	input wire plus_single_ended_out
);
	// ********
	// Relations
	// ********
	// Pin paths take two sync stages plus the output register
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_pd; power_down |-> $past(suspend_pin, 3); endproperty
	a_pd: assert property (p_pd)
		else $error("power-down without suspend pin");
	property p_fs; full_speed |-> $past(speed_pin, 3); endproperty
	a_fs: assert property (p_fs)
		else $error("full speed without speed pin");
	property p_keep; !power_down |-> analog_keep_on; endproperty
	a_keep: assert property (p_keep)
		else $error("analog off outside power-down");
	property p_bidi;
		!data_or_plus_pin_oen && op_mode == `TMC_MODE_USB |-> $past(driver_output_enable_n, 3);
	endproperty
	a_bidi: assert property (p_bidi)
		else $error("shared pin driven while enable low");
	property p_rcv;
		!diff_receive_oen && op_mode == `TMC_MODE_USB |-> $past(driver_output_enable_n, 3);
	endproperty
	a_rcv: assert property (p_rcv)
		else $error("receive output driven while enable low");
	property p_aud;
		op_mode == `TMC_MODE_AUDIO |-> line_pull == 4'h0 && line_plus_oen && line_minus_oen
			&& !id_ground;
	endproperty
	a_aud: assert property (p_aud)
		else $error("line held in audio mode");
	property p_avb; op_mode == `TMC_MODE_AUDIO |-> !vbus_supply; endproperty
	a_avb: assert property (p_avb)
		else $error("bus power in audio mode");
	property p_aoe; op_mode == `TMC_MODE_AUDIO |-> $past(driver_output_enable_n, 3); endproperty
	a_aoe: assert property (p_aoe)
		else $error("audio mode with enable low");
	property p_drv; !op_mode[1] |-> diff_driver_mode == !op_mode[0]; endproperty
	a_drv: assert property (p_drv)
		else $error("driver kind does not follow mode");
	property p_se; $past(hresetn, 3) |-> plus_single_ended_out == $past(rx_plus, 3); endproperty
	a_se: assert property (p_se)
		else $error("plus receiver output wrong");
	c_pd: cover property (power_down);
	c_aud: cover property (op_mode == `TMC_MODE_AUDIO);
	c_uart: cover property (op_mode == `TMC_MODE_UART);
endmodule

//--- test/tmc_link_model.sv
// Behavioural link controller side of the two shared data pins
`timescale 1ns/1ps
module tmc_link_model (
	input wire hclk,
	input wire tx_on,
	input wire tx_dat,
	input wire data_or_plus_pin_o,
	input wire data_or_plus_pin_oen,
	input wire single_zero_or_minus_pin_o,
	input wire single_zero_or_minus_pin_oen,
	output wire data_or_plus_pin_i,
	output wire single_zero_or_minus_pin_i
);
	// ********
	// Pin levels
	// ********
	logic last_p = 1'b0;
	logic last_m = 1'b0;
	// No pull on these pins, so a floating pin toggles rather than holding its value
	always @(posedge hclk)
	begin
		last_p <= data_or_plus_pin_i;
		last_m <= single_zero_or_minus_pin_i;
	end
	assign data_or_plus_pin_i = !data_or_plus_pin_oen ? data_or_plus_pin_o :
		tx_on ? tx_dat : ~last_p;
	assign single_zero_or_minus_pin_i = !single_zero_or_minus_pin_oen ?
		single_zero_or_minus_pin_o : tx_on ? ~tx_dat : ~last_m;
endmodule

//--- test/tmc_mode_ctrl_bench.sv
// Self-checking bench for the transceiver mode control block
`timescale 1ns/1ps
module tmc_mode_ctrl_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic suspend_pin = 1'b0;
	logic speed_pin = 1'b0;
	logic driver_output_enable_n = 1'b0;
	logic rx_diff = 1'b0;
	logic rx_plus = 1'b0;
	logic rx_minus = 1'b0;
	logic rx_se0 = 1'b0;
	logic tx_on = 1'b0;
	logic tx_dat = 1'b0;
	logic [7:0] line_status = 8'h00;
	logic [31:0] rd;
	int n_fail = 0;
	int compares = 0;
	wire hreadyout, data_or_plus_pin_i, data_or_plus_pin_o, data_or_plus_pin_oen;
	wire single_zero_or_minus_pin_i, single_zero_or_minus_pin_o, single_zero_or_minus_pin_oen;
	wire diff_receive_oen, plus_single_ended_out, line_plus_o, line_plus_oen, line_minus_o;
	wire line_minus_oen, full_speed, diff_driver_mode, power_down, analog_keep_on;
	wire id_ground, vbus_supply;
	wire [31:0] hrdata;
	wire [1:0] op_mode;
	wire [3:0] line_pull;

	tmc_mode_ctrl u_tmc_mode_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp(), .suspend_pin,
		.speed_pin, .driver_output_enable_n, .data_or_plus_pin_i, .data_or_plus_pin_o,
		.data_or_plus_pin_oen, .single_zero_or_minus_pin_i, .single_zero_or_minus_pin_o,
		.single_zero_or_minus_pin_oen, .rx_diff, .rx_plus, .rx_minus, .rx_se0, .line_status,
		.diff_receive_out(), .diff_receive_oen, .plus_single_ended_out,
		.minus_single_ended_out(), .line_plus_o, .line_plus_oen, .line_minus_o,
		.line_minus_oen, .full_speed, .diff_driver_mode, .op_mode, .power_down, .analog_keep_on,
		.line_pull, .id_ground, .vbus_supply, .vbus_discharge(), .vbus_charge(),
		.ext_pump_en(), .rec_bias());
	tmc_link_model u_tmc_link_model (.hclk, .tx_on, .tx_dat, .data_or_plus_pin_o,
		.data_or_plus_pin_oen, .single_zero_or_minus_pin_o, .single_zero_or_minus_pin_oen,
		.data_or_plus_pin_i, .single_zero_or_minus_pin_i);

	always #5 hclk = ~hclk;

	// ********
	// Bus tasks
	// ********
	task xfer(input [5:0] i, input w, input [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, i, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task rdc(input [5:0] i, input [7:0] e);
		xfer(i, 1'b0, 8'h00);
		chk(rd, {24'h0, e});
	endtask
	// Outputs follow pins after three edges
	task st;
		repeat (3) @(posedge hclk);
		#1;
	endtask
	task pin(input s, input f, input o);
		@(posedge hclk);
		suspend_pin <= s;
		speed_pin <= f;
		driver_output_enable_n <= o;
		st;
	endtask
	task final_report;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ********
	// Tests
	// ********
	initial
	begin
		#50000;
		n_fail++;
		final_report;
	end
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(6'h04, 8'h03);
		rdc(6'h06, 8'h0c);
		rdc(6'h12, 8'h14);
		xfer(6'h3f, 1'b1, 8'hff);
		rdc(6'h3f, 8'h00);
		pin(1'b0, 1'b1, 1'b1);
		chk(power_down, 1'b0);
		chk(full_speed, 1'b1);
		pin(1'b1, 1'b0, 1'b1);
		chk(power_down, 1'b1);
		chk(full_speed, 1'b0);
		chk(analog_keep_on, 1'b0);
		xfer(6'h06, 1'b1, 8'h01);
		st;
		chk(analog_keep_on, 1'b1);
		xfer(6'h07, 1'b1, 8'h01);
		xfer(6'h05, 1'b1, 8'h02);
		rdc(6'h05, 8'h01);
		chk(power_down, 1'b0);
		xfer(6'h04, 1'b1, 8'h48);
		rdc(6'h04, 8'h41);
		chk(op_mode, 2'h1);
		chk(diff_driver_mode, 1'b0);
		tx_on <= 1'b1;
		tx_dat <= 1'b1;
		rx_plus <= 1'b1;
		rx_minus <= 1'b1;
		for (int b = 0; b < 4; b++)
		begin
			xfer(6'h13, 1'b1, 8'h18);
			xfer(6'h12, 1'b1, 8'(b << 3));
			st;
			chk({line_plus_oen, data_or_plus_pin_oen, line_minus_oen, single_zero_or_minus_pin_oen},
				{b[1], !b[1], b[0], !b[0]});
			chk(b[1] ? data_or_plus_pin_o : line_plus_o, 1'b1);
			chk(b[0] ? single_zero_or_minus_pin_o : line_minus_o, b[0]);
		end
		xfer(6'h13, 1'b1, 8'h18);
		xfer(6'h12, 1'b1, 8'h10);
		xfer(6'h05, 1'b1, 8'h40);
		xfer(6'h04, 1'b1, 8'h08);
		st;
		chk(op_mode, 2'h3);
		xfer(6'h05, 1'b1, 8'h08);
		st;
		chk(op_mode, 2'h0);
		chk(diff_driver_mode, 1'b1);
		tx_on <= 1'b0;
		rx_diff <= 1'b1;
		rx_plus <= 1'b0;
		for (int e = 0; e < 2; e++)
		begin
			xfer(e ? 6'h04 : 6'h05, 1'b1, 8'h04);
			st;
			chk({data_or_plus_pin_oen, single_zero_or_minus_pin_oen, diff_receive_oen},
				{2'h0, e[0]});
			chk({data_or_plus_pin_o, single_zero_or_minus_pin_o}, e ? 2'h2 : 2'h1);
		end
		pin(1'b0, 1'b0, 1'b0);
		chk({data_or_plus_pin_oen, single_zero_or_minus_pin_oen, diff_receive_oen}, 3'h7);
		pin(1'b0, 1'b0, 1'b1);
		xfer(6'h13, 1'b1, 8'h04);
		st;
		chk({data_or_plus_pin_oen, single_zero_or_minus_pin_oen}, 2'h3);
		xfer(6'h12, 1'b1, 8'h04);
		xfer(6'h07, 1'b1, 8'hff);
		st;
		chk(op_mode, 2'h2);
		chk({line_pull, line_plus_oen, line_minus_oen, id_ground, vbus_supply}, 8'h0c);
		xfer(6'h06, 1'b1, 8'h20);
		st;
		chk(op_mode, 2'h0);
		line_status <= 8'h03;
		st;
		rdc(6'h08, 8'h03);
		xfer(6'h04, 1'b1, 8'h02);
		pin(1'b1, 1'b0, 1'b1);
		chk(power_down, 1'b1);
		xfer(6'h0e, 1'b1, 8'h48);
		line_status <= 8'h4b;
		st;
		rdc(6'h0a, 8'h08);
		xfer(6'h0b, 1'b1, 8'hff);
		rdc(6'h0a, 8'h00);
		final_report;
	end
endmodule

bind tmc_mode_ctrl tmc_mode_ctrl_asserts u_tmc_mode_ctrl_asserts (.hclk, .hresetn, .suspend_pin,
	.speed_pin, .driver_output_enable_n, .rx_plus, .data_or_plus_pin_oen, .diff_receive_oen,
	.line_pull, .line_plus_oen, .line_minus_oen, .id_ground, .vbus_supply, .op_mode,
	.diff_driver_mode, .power_down, .analog_keep_on, .full_speed, .plus_single_ended_out);
